// File: verilog/amlc_pkg.sv
// constants for the alarm routing control block
// assumes a host port outside that presents plain register strobes
// Operation
// [RULE1] control bit 10 routes local low event to pin; flag always sets
// [RULE2] control bit 9 routes local high event to pin; flag always sets
// [RULE3] control bit 8 routes remote one low event to pin
// [RULE4] control bit 7 routes remote one high event to pin
// [RULE5] control bit 6 routes remote two low event to pin
// [RULE6] control bit 5 routes remote two high event to pin
// [RULE7] control bit 4 routes remote one fault to pin; fault flag always sets
// [RULE8] control bit 3 routes remote two fault to pin; fault flag always sets
// [RULE9] bit 2 low: flags stick until condition gone and status read
// [RULE10] bit 2 high: flags follow live condition, no read needed
// [RULE11] bits 1 and 0 ignore writes and read zero
// [RULE12] after reset bits 10 down to 2 read zero
// [RULE13] status read clears flags; persisting conditions set again next conversion; code clears only flags whose event is low at the read
// [RULE14] thermal flag always pulls pin low when pin enabled
// [RULE15] pin low while any routed flag set and pin enabled
package amlc_pkg;
  localparam int NUM_EVENTS = 8;
  localparam logic [7:0] ROUTING_OFFSET = 8'h4E;
  localparam logic [7:0] STATUS_OFFSET = 8'h4F;
  localparam int ROUTE_LSB = 3;
  localparam int STICKY_DIS_BIT = 2;
  localparam logic [15:0] ROUTING_RESET = 16'h0000;
  localparam logic [15:0] ROUTING_WMASK = 16'h07FC;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage

// File: verilog/amlc_alarm_mask_latch_ctrl.sv
// alarm routing control register, status flags and alarm pin
// assumes host port gives one-cycle read/write strobes on ref_clk_in
// event levels and conversion strobe come from logic on the same clock
`timescale 1ns/1ps
module amlc_alarm_mask_latch_ctrl (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // events, bit 7 local under ... bit 0 remote two fault
  input wire logic [7:0] event_level_in,
  input wire logic conversion_done_in,
  input wire logic thermal_flag_in,
  input wire logic alarm_pin_enable_in,
  output logic [7:0] status_flags_out,
  output logic alarm_n_out,
  output logic alarm_n_oe_out
);

  //////////////////////////////////////////////////////////////////////
  logic [15:0] routing_reg, routing_next;
  logic [7:0] flags_reg, flags_next;
  logic [15:0] rdata_reg, rdata_next;
  logic alarm_reg, alarm_next;
  logic rd_status, wr_routing;
  logic [7:0] route_en;
  logic sticky_dis;

  assign rd_status = reg_rd_in && (reg_addr_in == amlc_pkg::STATUS_OFFSET);
  assign wr_routing = reg_wr_in && (reg_addr_in == amlc_pkg::ROUTING_OFFSET);
  assign route_en = routing_reg[amlc_pkg::ROUTE_LSB +: amlc_pkg::NUM_EVENTS];
  assign sticky_dis = routing_reg[amlc_pkg::STICKY_DIS_BIT];

  //////////////////////////////////////////////////////////////////////
  always_comb
  begin
    routing_next = routing_reg;
    if (wr_routing)
    begin
      // bits 15..11 belong to other channel logic; 1 and 0 reserved
      routing_next = reg_wdata_in & amlc_pkg::ROUTING_WMASK; // [RULE11]
    end
  end

  // flag update: latched events sampled on conversion, live events (bit 2 high) every cycle; set beats clear
  always_comb
  begin
    flags_next = flags_reg;
    for (int i = 0; i < amlc_pkg::NUM_EVENTS; i++)
    begin
      if (sticky_dis)
      begin
        flags_next[i] = event_level_in[i]; // [RULE10]
      end
      else
      begin
        if (rd_status)
        begin
          flags_next[i] = 1'b0; // [RULE13]
        end
        if (rd_status && event_level_in[i])
        begin
          // still out of range at read: stays set until a read after it subsides
          flags_next[i] = 1'b1; // [RULE9]
        end
        if (conversion_done_in && event_level_in[i])
        begin
          flags_next[i] = 1'b1; // [RULE13]
        end
      end
    end
  end

  always_comb
  begin
    rdata_next = 16'h0000;
    if (reg_rd_in && reg_addr_in == amlc_pkg::ROUTING_OFFSET)
    begin
      rdata_next = routing_reg & amlc_pkg::ROUTING_WMASK; // [RULE11]
    end
    else if (rd_status)
    begin
      rdata_next = {5'h00, flags_reg, 3'h0};
    end
    // pin routing: thermal cannot be masked
    alarm_next = alarm_pin_enable_in &&
      (thermal_flag_in || |(flags_reg & route_en)); // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE14] [RULE15]
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      routing_reg <= amlc_pkg::ROUTING_RESET; // [RULE12]
      flags_reg <= amlc_pkg::FLAGS_RESET;
      rdata_reg <= 16'h0000;
      alarm_reg <= 1'b0;
    end
    else
    begin
      routing_reg <= routing_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
      alarm_reg <= alarm_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign status_flags_out = flags_reg;
  // open drain: drive low only
  assign alarm_n_out = 1'b0;
  assign alarm_n_oe_out = alarm_reg;

  //////////////////////////////////////////////////////////////////////
  pin_routed_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (alarm_pin_enable_in && |(flags_reg & route_en)) |=> alarm_n_oe_out) // [RULE15]
    else $error("routed flag did not pull alarm low");
  pin_masked_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!thermal_flag_in && !(|(flags_reg & route_en))) |=> !alarm_n_oe_out) // [RULE1]
    else $error("masked flag pulled alarm low");
  thermal_pin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (thermal_flag_in && alarm_pin_enable_in) |=> alarm_n_oe_out) // [RULE14]
    else $error("thermal flag did not pull alarm low");
  pin_disable_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !alarm_pin_enable_in |=> !alarm_n_oe_out) // [RULE15]
    else $error("alarm driven while pin disabled");
  sticky_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!sticky_dis && !rd_status && flags_reg[0]) |=> flags_reg[0]) // [RULE9]
    else $error("latched flag cleared without read");
  live_follow_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    sticky_dis |=> flags_reg == $past(event_level_in)) // [RULE10]
    else $error("unlatched flag did not follow condition");
  read_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (!sticky_dis && rd_status && !conversion_done_in && event_level_in == 8'h00)
      |=> flags_reg == 8'h00) // [RULE13]
    else $error("status read did not clear flags");
  reserved_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    routing_reg[1:0] == 2'h0 && reg_rdata_out[1:0] == 2'h0) // [RULE11]
    else $error("reserved bits not zero");
  flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (conversion_done_in && event_level_in[7]) |=> status_flags_out[7]) // [RULE1]
    else $error("event did not set its flag");

  //////////////////////////////////////////////////////////////////////
  // register side checks
  routing_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_routing |=> routing_reg == ($past(reg_wdata_in) & amlc_pkg::ROUTING_WMASK)) // [RULE11]
    else $error("routing write not masked");
  routing_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !wr_routing |=> $stable(routing_reg)) // [RULE11]
    else $error("routing changed without write");
  rdata_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !reg_rd_in |=> reg_rdata_out == 16'h0000) // [RULE11]
    else $error("read data not idle");
  upper_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    reg_rdata_out[15:11] == 5'h00) // [RULE11]
    else $error("unimplemented bits not zero");
  status_read_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_status |=> reg_rdata_out == {5'h00, $past(flags_reg), 3'h0}) // [RULE13]
    else $error("status read returned wrong flags");
  // sampled values at the release edge still hold the reset state
  reset_state_a: assert property (@(posedge ref_clk_in)
    $rose(rst_n_in) |-> (routing_reg == 16'h0000 && flags_reg == 8'h00 && !alarm_n_oe_out)) // [RULE12]
    else $error("state not cleared by reset");

  //////////////////////////////////////////////////////////////////////
  // per event checks; bit 0 alone would miss a broken index
  genvar g;
  for (g = 0; g < amlc_pkg::NUM_EVENTS; g++)
  begin : gen_flag_checks
    flag_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!sticky_dis && !rd_status && flags_reg[g]) |=> flags_reg[g]) // [RULE9]
      else $error("latched flag cleared without read");
    flag_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!sticky_dis && !conversion_done_in && !flags_reg[g]) |=> !flags_reg[g]) // [RULE9]
      else $error("latched flag rose without conversion");
    flag_catch_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!sticky_dis && conversion_done_in && event_level_in[g]) |=> flags_reg[g]) // [RULE13]
      else $error("conversion did not set flag");
    flag_release_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (!sticky_dis && rd_status && !conversion_done_in && !event_level_in[g])
        |=> !flags_reg[g]) // [RULE13]
      else $error("read did not clear resolved flag");
    live_bit_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      sticky_dis |=> flags_reg[g] == $past(event_level_in[g])) // [RULE10]
      else $error("unlatched flag did not follow its event");
    route_bit_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (alarm_pin_enable_in && route_en[g] && flags_reg[g]) |=> alarm_n_oe_out) // [RULE15]
      else $error("routed event did not pull alarm low");
  end

endmodule

// File: tb/amlc_alarm_mask_latch_ctrl_tb.sv
// bench for the alarm routing control block
// drives host strobes, event levels and pin enable itself on ref_clk_in
`timescale 1ns/1ps
module amlc_alarm_mask_latch_ctrl_tb;
  logic ref_clk_in, rst_n_in, wr, rd, cd, therm, pen, oe, pin_n;
  logic [7:0] addr, ev, flags;
  logic [15:0] wd, rdata;
  logic [24:0] rows [16];
  int mismatches, comparisons;
  amlc_alarm_mask_latch_ctrl uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
    .reg_rdata_out(rdata), .event_level_in(ev), .conversion_done_in(cd),
    .thermal_flag_in(therm), .alarm_pin_enable_in(pen), .status_flags_out(flags),
    .alarm_n_out(pin_n), .alarm_n_oe_out(oe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask
  // read data is registered, so sample just after the strobe is taken
  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  // flags land one edge after the pulse, the pin pull (oe) one edge later
  task automatic conv();
    @(posedge ref_clk_in);
    cd <= 1'b1;
    @(posedge ref_clk_in);
    cd <= 1'b0;
    @(posedge ref_clk_in);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    #100us;
    mismatches++;
    conclude();
  end
  initial
  begin
    {rst_n_in, wr, rd, cd, therm, addr, ev, wd} = '0;
    pen = 1'b1;
    // row: routing word, event levels, expected pin pull
    for (int i = 0; i < 8; i++)
    begin
      rows[2*i] = {16'h0008 << i, 8'h01 << i, 1'b1};
      rows[2*i+1] = {16'h07F8 & ~(16'h0008 << i), 8'h01 << i, 1'b0};
    end
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd_reg(8'h4E, 16'h0000);
    wr_reg(8'h4E, 16'hFFFF);
    rd_reg(8'h4E, 16'h07FC);
    rd_reg(8'h10, 16'h0000);
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd_reg(8'h4E, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      wr_reg(8'h4E, rows[i][24:9]);
      ev <= rows[i][8:1];
      conv();
      chk("flags", {8'h00, flags}, {8'h00, rows[i][8:1]});
      chk("oe", {15'h0, oe}, {15'h0, rows[i][0]});
      chk("pin", {15'h0, pin_n}, 16'h0000);
      @(posedge ref_clk_in);
      ev <= 8'h00;
      repeat (2) @(posedge ref_clk_in);
      #1 chk("sticky", {8'h00, flags}, {8'h00, rows[i][8:1]});
      rd_reg(8'h4F, {5'h00, rows[i][8:1], 3'h0});
      chk("cleared", {8'h00, flags}, 16'h0000);
    end
    ev <= 8'h80;
    conv();
    rd_reg(8'h4F, 16'h0400);
    chk("kept", {8'h00, flags}, 16'h0080);
    ev <= 8'h00;
    wr_reg(8'h4E, 16'h0004);
    ev <= 8'h41;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("live", {8'h00, flags}, 16'h0041);
    ev <= 8'h00;
    repeat (2) @(posedge ref_clk_in);
    #1 chk("live", {8'h00, flags}, 16'h0000);
    wr_reg(8'h4E, 16'h0000);
    therm <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    #1 chk("therm", {15'h0, oe}, 16'h0001);
    pen <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1 chk("therm", {15'h0, oe}, 16'h0000);
    conclude();
  end
endmodule
